// File: rtl/adc_ctl_pkg.sv
// Shared constants, types and decode functions for the converter controller
package adc_ctl_pkg;

    localparam int NUM_CHANNELS = 13;
    localparam int CFG_WIDTH = 17;

    // Device register map, reached over the device register port
    localparam logic [3:0] DEV_CTRL0 = 4'h0;
    localparam logic [3:0] DEV_CTRL1 = 4'h1;
    localparam logic [3:0] DEV_CTRL2 = 4'h2;
    localparam logic [3:0] DEV_RES_HI = 4'h3;
    localparam logic [3:0] DEV_RES_LO = 4'h4;
    localparam logic [3:0] DEV_FLAG = 4'h5;
    localparam logic [3:0] DEV_IRQ_EN = 4'h6;
    localparam logic [3:0] DEV_DIR_LO = 4'h7;
    localparam logic [3:0] DEV_DIR_HI = 4'h8;

    // Device field positions
    localparam int CTRL0_ON_BIT = 0;
    localparam int CTRL0_GO_BIT = 1;
    localparam int IRQ_CONV_BIT = 0;
    localparam int IRQ_GLOBAL_BIT = 1;

    // Controller registers, word addresses on the Avalon slave
    localparam logic [2:0] REG_CMD = 3'h0;
    localparam logic [2:0] REG_CFG = 3'h1;
    localparam logic [2:0] REG_TAD = 3'h2;
    localparam logic [2:0] REG_ACQ_WAIT = 3'h3;
    localparam logic [2:0] REG_FOSC = 3'h4;
    localparam logic [2:0] REG_RESULT = 3'h5;

    localparam int CMD_START_BIT = 0;
    localparam int CMD_IRQ_MODE_BIT = 1;

    // Reset values
    localparam logic [CFG_WIDTH-1:0] CFG_RESET = 17'h00000;
    localparam logic [15:0] TAD_RESET = 16'h0010;
    localparam logic [15:0] ACQ_WAIT_RESET = 16'h0100;
    localparam logic [15:0] FOSC_RESET = 16'h9C40;

    // Oscillator limits in kHz
    localparam logic [15:0] FOSC_RC_LIMIT_KHZ = 16'h03E8;
    localparam logic [15:0] FOSC_MAX_DIV2 = 16'h09C4;
    localparam logic [15:0] FOSC_MAX_DIV4 = 16'h1388;
    localparam logic [15:0] FOSC_MAX_DIV8 = 16'h2710;
    localparam logic [15:0] FOSC_MAX_DIV16 = 16'h4E20;
    localparam logic [15:0] FOSC_MAX_DIV32 = 16'h9C40;

    typedef struct packed {
        logic sleep_ok;
        logic [2:0] clk_sel;
        logic [2:0] acq;
        logic [3:0] chan;
        logic neg_ref;
        logic pos_ref;
        logic [3:0] pcfg;
    } cfg_t;

    typedef struct packed {
        logic write;
        logic [3:0] addr;
        logic [7:0] wdata;
    } dev_req_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_WR_CFG1 = 4'h1,
        ST_WR_CFG2 = 4'h3,
        ST_WR_DIRL = 4'h2,
        ST_WR_DIRH = 4'h6,
        ST_WR_ON = 4'h7,
        ST_CLR_FLAG = 4'h5,
        ST_WR_IRQ = 4'h4,
        ST_ACQ_WAIT = 4'hC,
        ST_WR_GO = 4'hD,
        ST_POLL = 4'hF,
        ST_GAP = 4'hE,
        ST_RD_HI = 4'hA,
        ST_RD_LO = 4'hB,
        ST_CLR_DONE = 4'h9
    } seq_state_t;

    function automatic logic is_rc(input logic [2:0] sel);
        return sel[1:0] == 2'b11;
    endfunction

    function automatic logic [15:0] max_fosc_khz(input logic [2:0] sel);
        case (sel)
            3'h0: max_fosc_khz = FOSC_MAX_DIV2;
            3'h4: max_fosc_khz = FOSC_MAX_DIV4;
            3'h1: max_fosc_khz = FOSC_MAX_DIV8;
            3'h5: max_fosc_khz = FOSC_MAX_DIV16;
            3'h2: max_fosc_khz = FOSC_MAX_DIV32;
            3'h6: max_fosc_khz = FOSC_MAX_DIV32;
            default: max_fosc_khz = FOSC_RC_LIMIT_KHZ;
        endcase
    endfunction

    // Channel k is analog while code + k stays below 15
    function automatic logic [NUM_CHANNELS-1:0] analog_mask(
        input logic [3:0] pcfg);
        logic [NUM_CHANNELS-1:0] m;
        m = '0;
        for (int k = 0; k < NUM_CHANNELS; k++) begin
            m[k] = (5'(pcfg) + 5'(k)) < 5'd15;
        end
        return m;
    endfunction

endpackage

// File: rtl/dev_port.sv
// One-access-at-a-time master for the device register port
`timescale 1ns/1ps
module dev_port (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic go,
    input wire adc_ctl_pkg::dev_req_t req,
    output logic done,
    output logic [7:0] rdata,
    output logic [3:0] dev_addr,
    output logic [7:0] dev_wdata,
    output logic dev_we,
    output logic dev_re,
    input wire logic [7:0] dev_rdata,
    input wire logic dev_ack
);
    import adc_ctl_pkg::*;

    typedef struct packed {
        logic active;
        logic done;
        dev_req_t req;
        logic [7:0] rdata;
    } port_state_t;

    port_state_t s_reg;
    port_state_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (!s_reg.active && go) begin
            s_next.active = 1'b1;
            s_next.req = req;
        end
        if (s_reg.active && dev_ack) begin
            s_next.active = 1'b0;
            s_next.done = 1'b1;
            if (!s_reg.req.write) begin
                s_next.rdata = dev_rdata;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign done = s_reg.done;
    assign rdata = s_reg.rdata;
    assign dev_addr = s_reg.req.addr;
    assign dev_wdata = s_reg.req.wdata;
    assign dev_we = s_reg.active && s_reg.req.write;
    assign dev_re = s_reg.active && !s_reg.req.write;

    a_one_strobe: assert property (@(posedge CLK) disable iff (!RST_N)
        !(dev_we && dev_re))
        else $error("read and write strobes high together");

endmodule

// File: rtl/adc_ctl.sv
// Converter sequencing controller with Avalon-MM command registers
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Setting start bit begins acquire then convert
// - Manual mode: wait acquisition before start
// - Pick fastest legal divider for oscillator; the block does not pick one, it refuses a divider too fast for it or used below 1 MHz
// - Wait two clock periods before next acquisition
// - Configure everything, then switch converter on
// - Set analog channel pins to input
// - Clear flag, enable interrupts, then start
// - After completion read result, clear flag
// - Keep clock source steady during conversion
// - RC above 1 MHz needs sleep
// - Below 1 MHz use RC conversion clock
module adc_ctl (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [2:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic [3:0] DEV_ADDR,
    output logic [7:0] DEV_WDATA,
    output logic DEV_WE,
    output logic DEV_RE,
    input wire logic [7:0] DEV_RDATA,
    input wire logic DEV_ACK,
    input wire logic DEV_IRQ,
    output logic CLK_HOLD,
    output logic SLEEP_REQ
);
    import adc_ctl_pkg::*;

    typedef struct packed {
        seq_state_t st;
        logic issued;
        logic [16:0] timer;
        logic done;
        logic err;
        logic irq_mode;
        logic [11:0] result;
        cfg_t cfg;
        logic [15:0] conversion_clock_period;
        logic [15:0] acq_wait;
        logic [15:0] fosc;
        logic rdv;
        logic [31:0] rdata;
    } ctl_state_t;

    ctl_state_t s_reg;
    ctl_state_t s_next;
    logic acc_go;
    dev_req_t acc_req;
    logic acc_done;
    logic [7:0] acc_rdata;
    logic is_acc;
    seq_state_t after;
    logic [NUM_CHANNELS-1:0] mask;
    logic bad_clock;
    logic busy;
    cfg_t new_cfg;

    assign busy = s_reg.st != ST_IDLE;
    assign mask = analog_mask(s_reg.cfg.pcfg);

    // Oscillator versus clock select legality
    always_comb begin
        bad_clock = 1'b0;
        if (s_reg.fosc > max_fosc_khz(s_reg.cfg.clk_sel)) begin
            bad_clock = !is_rc(s_reg.cfg.clk_sel);
        end
        if (s_reg.fosc < FOSC_RC_LIMIT_KHZ && !is_rc(s_reg.cfg.clk_sel)) begin
            bad_clock = 1'b1;
        end
        if (is_rc(s_reg.cfg.clk_sel) && s_reg.fosc > FOSC_RC_LIMIT_KHZ
            && !s_reg.cfg.sleep_ok) begin
            bad_clock = 1'b1;
        end
        if (s_reg.conversion_clock_period == 16'h0000) begin
            bad_clock = 1'b1;
        end
    end

    always_comb begin
        s_next = s_reg;
        acc_go = 1'b0;
        is_acc = 1'b1;
        after = s_reg.st;
        new_cfg = cfg_t'(AVS_WRITEDATA[CFG_WIDTH-1:0]);
        acc_req = '{write: 1'b1, addr: DEV_CTRL0, wdata: 8'h00};

        // Avalon read: one wait cycle, data from a register
        s_next.rdv = AVS_READ && !s_reg.rdv;
        if (AVS_READ && !s_reg.rdv) begin
            case (AVS_ADDRESS)
                REG_CMD: s_next.rdata = {29'h0, s_reg.err, s_reg.done, busy};
                REG_CFG: s_next.rdata = {15'h0, s_reg.cfg};
                REG_TAD: s_next.rdata = {16'h0, s_reg.conversion_clock_period};
                REG_ACQ_WAIT: s_next.rdata = {16'h0, s_reg.acq_wait};
                REG_FOSC: s_next.rdata = {16'h0, s_reg.fosc};
                REG_RESULT: s_next.rdata = {20'h0, s_reg.result};
                default: s_next.rdata = 32'h0000_0000;
            endcase
        end

        // Avalon write: configuration locked while busy
        if (AVS_WRITE && !busy) begin
            case (AVS_ADDRESS)
                REG_CMD: begin
                    if (AVS_WRITEDATA[CMD_START_BIT]) begin
                        s_next.done = 1'b0;
                        s_next.err = bad_clock;
                        s_next.irq_mode = AVS_WRITEDATA[CMD_IRQ_MODE_BIT];
                        s_next.issued = 1'b0;
                        s_next.timer = '0;
                        if (!bad_clock) begin
                            s_next.st = ST_WR_CFG1;
                        end
                    end
                end
                REG_CFG: s_next.cfg = new_cfg;
                REG_TAD: s_next.conversion_clock_period = AVS_WRITEDATA[15:0];
                REG_ACQ_WAIT: s_next.acq_wait = AVS_WRITEDATA[15:0];
                REG_FOSC: s_next.fosc = AVS_WRITEDATA[15:0];
                default: ;
            endcase
        end

        case (s_reg.st)
            ST_IDLE: is_acc = 1'b0;
            ST_WR_CFG1: begin
                acc_req = '{1'b1, DEV_CTRL1, {2'b00, s_reg.cfg.neg_ref,
                    s_reg.cfg.pos_ref, s_reg.cfg.pcfg}};
                after = ST_WR_CFG2;
            end
            ST_WR_CFG2: begin
                acc_req = '{1'b1, DEV_CTRL2, {2'b00, s_reg.cfg.acq,
                    s_reg.cfg.clk_sel}};
                after = ST_WR_DIRL;
            end
            ST_WR_DIRL: begin
                acc_req = '{1'b1, DEV_DIR_LO, mask[7:0]};
                after = ST_WR_DIRH;
            end
            ST_WR_DIRH: begin
                acc_req = '{1'b1, DEV_DIR_HI, {3'b000, mask[12:8]}};
                after = ST_WR_ON;
            end
            ST_WR_ON: begin
                acc_req = '{1'b1, DEV_CTRL0, {2'b00, s_reg.cfg.chan, 2'b01}};
                after = ST_CLR_FLAG;
            end
            ST_CLR_FLAG: begin
                acc_req = '{1'b1, DEV_FLAG, 8'h00};
                after = ST_WR_IRQ;
            end
            ST_WR_IRQ: begin
                acc_req = '{1'b1, DEV_IRQ_EN, 8'h00};
                acc_req.wdata[IRQ_CONV_BIT] = s_reg.irq_mode;
                acc_req.wdata[IRQ_GLOBAL_BIT] = s_reg.irq_mode;
                after = ST_ACQ_WAIT;
            end
            ST_ACQ_WAIT: begin
                is_acc = 1'b0;
                // Programmed acquisition needs no wait here
                if (s_reg.cfg.acq != 3'b000 ||
                    s_reg.timer >= {1'b0, s_reg.acq_wait}) begin
                    s_next.st = ST_WR_GO;
                    s_next.timer = '0;
                end else begin
                    s_next.timer = s_reg.timer + 17'h00001;
                end
            end
            ST_WR_GO: begin
                acc_req = '{1'b1, DEV_CTRL0, {2'b00, s_reg.cfg.chan, 2'b11}};
                after = ST_POLL;
            end
            ST_POLL: begin
                acc_req = '{1'b0, DEV_CTRL0, 8'h00};
                after = ST_POLL;
                if (s_reg.irq_mode) begin
                    is_acc = 1'b0;
                    if (DEV_IRQ) begin
                        s_next.st = ST_GAP;
                    end
                end else if (acc_done && !acc_rdata[CTRL0_GO_BIT]) begin
                    after = ST_GAP;
                end
            end
            ST_GAP: begin
                is_acc = 1'b0;
                if (s_reg.timer >= {s_reg.conversion_clock_period, 1'b0}) begin
                    s_next.st = ST_RD_HI;
                    s_next.timer = '0;
                end else begin
                    s_next.timer = s_reg.timer + 17'h00001;
                end
            end
            ST_RD_HI: begin
                acc_req = '{1'b0, DEV_RES_HI, 8'h00};
                after = ST_RD_LO;
                if (acc_done) begin
                    s_next.result[11:8] = acc_rdata[3:0];
                end
            end
            ST_RD_LO: begin
                acc_req = '{1'b0, DEV_RES_LO, 8'h00};
                after = ST_CLR_DONE;
                if (acc_done) begin
                    s_next.result[7:0] = acc_rdata;
                end
            end
            ST_CLR_DONE: begin
                acc_req = '{1'b1, DEV_FLAG, 8'h00};
                after = ST_IDLE;
                if (acc_done) begin
                    s_next.done = 1'b1;
                end
            end
            default: begin
                is_acc = 1'b0;
                s_next.st = ST_IDLE;
            end
        endcase

        // Common access sequencing: issue once, advance on done
        if (is_acc) begin
            if (!s_reg.issued) begin
                acc_go = 1'b1;
                s_next.issued = 1'b1;
            end else if (acc_done) begin
                s_next.issued = 1'b0;
                s_next.st = after;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_reg <= '{st: ST_IDLE, issued: 1'b0, timer: 17'h00000,
                done: 1'b0, err: 1'b0, irq_mode: 1'b0, result: 12'h000,
                cfg: CFG_RESET, conversion_clock_period: TAD_RESET, acq_wait: ACQ_WAIT_RESET,
                fosc: FOSC_RESET, rdv: 1'b0, rdata: 32'h0000_0000};
        end else begin
            s_reg <= s_next;
        end
    end

    dev_port u_port (
        .CLK(CLK),
        .RST_N(RST_N),
        .go(acc_go),
        .req(acc_req),
        .done(acc_done),
        .rdata(acc_rdata),
        .dev_addr(DEV_ADDR),
        .dev_wdata(DEV_WDATA),
        .dev_we(DEV_WE),
        .dev_re(DEV_RE),
        .dev_rdata(DEV_RDATA),
        .dev_ack(DEV_ACK)
    );

    assign AVS_READDATA = s_reg.rdata;
    assign AVS_WAITREQUEST = AVS_READ && !s_reg.rdv;
    assign CLK_HOLD = s_reg.st == ST_WR_GO || s_reg.st == ST_POLL;
    assign SLEEP_REQ = CLK_HOLD && is_rc(s_reg.cfg.clk_sel)
        && s_reg.fosc > FOSC_RC_LIMIT_KHZ;

    // Helper: cycles spent in the gap and acquisition waits
    logic [16:0] wait_cnt;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wait_cnt <= '0;
        end else if (s_reg.st == ST_GAP || s_reg.st == ST_ACQ_WAIT) begin
            wait_cnt <= wait_cnt + 17'h00001;
        end else begin
            wait_cnt <= '0;
        end
    end

    a_bad_clock_err: assert property (@(posedge CLK) disable iff (!RST_N)
        (AVS_WRITE && !busy && AVS_ADDRESS == REG_CMD
         && AVS_WRITEDATA[CMD_START_BIT] && bad_clock)
        |=> s_reg.err && s_reg.st == ST_IDLE)
        else $error("illegal clock choice started a conversion");

    a_low_fosc_rc: assert property (@(posedge CLK) disable iff (!RST_N)
        busy |-> !(s_reg.fosc < FOSC_RC_LIMIT_KHZ
                   && !is_rc(s_reg.cfg.clk_sel)))
        else $error("divider used below RC threshold");

    a_sleep_rc: assert property (@(posedge CLK) disable iff (!RST_N)
        (busy && is_rc(s_reg.cfg.clk_sel)
         && s_reg.fosc > FOSC_RC_LIMIT_KHZ) |-> s_reg.cfg.sleep_ok)
        else $error("RC clock above threshold without sleep");

    a_gap_min: assert property (@(posedge CLK) disable iff (!RST_N)
        (s_reg.st == ST_GAP && s_next.st != ST_GAP)
        |-> wait_cnt >= {s_reg.conversion_clock_period, 1'b0})
        else $error("gap after conversion too short");

    a_manual_acq: assert property (@(posedge CLK) disable iff (!RST_N)
        (s_reg.st == ST_ACQ_WAIT && s_next.st == ST_WR_GO
         && s_reg.cfg.acq == 3'b000)
        |-> wait_cnt >= {1'b0, s_reg.acq_wait})
        else $error("manual acquisition wait too short");

    a_go_with_on: assert property (@(posedge CLK) disable iff (!RST_N)
        (DEV_WE && DEV_ADDR == DEV_CTRL0 && DEV_WDATA[CTRL0_GO_BIT])
        |-> DEV_WDATA[CTRL0_ON_BIT] && $past(s_reg.st) == ST_WR_GO)
        else $error("start written without converter on");

    a_dir_input: assert property (@(posedge CLK) disable iff (!RST_N)
        (DEV_WE && DEV_ADDR == DEV_DIR_LO) |-> DEV_WDATA == mask[7:0])
        else $error("analog channel pin not set to input");

    a_irq_setup: assert property (@(posedge CLK) disable iff (!RST_N)
        (s_reg.st == ST_WR_IRQ && DEV_WE)
        |-> DEV_WDATA[IRQ_CONV_BIT] == s_reg.irq_mode
            && DEV_WDATA[IRQ_GLOBAL_BIT] == s_reg.irq_mode)
        else $error("interrupt enables wrong before start");

    a_hold_clock: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(s_reg.st == ST_POLL) |-> $past(CLK_HOLD) && CLK_HOLD)
        else $error("clock hold dropped during conversion");

    a_done_flag: assert property (@(posedge CLK) disable iff (!RST_N)
        (s_reg.st == ST_CLR_DONE && acc_done) |=> s_reg.done && !busy)
        else $error("completion not reported after flag clear");

    c_poll_done: cover property (@(posedge CLK) disable iff (!RST_N)
        s_reg.st == ST_POLL && !s_reg.irq_mode && s_next.st == ST_GAP);
    c_irq_done: cover property (@(posedge CLK) disable iff (!RST_N)
        s_reg.st == ST_POLL && s_reg.irq_mode && DEV_IRQ);
    c_manual_wait: cover property (@(posedge CLK) disable iff (!RST_N)
        s_reg.st == ST_ACQ_WAIT && s_reg.cfg.acq == 3'b000
        && wait_cnt > 17'h00002);
    c_error: cover property (@(posedge CLK) disable iff (!RST_N)
        $rose(s_reg.err));

endmodule

// File: tb/adc_dev_model.sv
// Behavioural converter device answering on the device register port
`timescale 1ns/1ps
module adc_dev_model #(
    parameter bit FUSE_PB_ANALOG = 1'b1,
    parameter int TAD_CYC = 2,
    parameter int INSTR_CYC = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic we,
    input wire logic re,
    input wire logic slow,
    output logic [7:0] rdata,
    output logic ack,
    output logic irq
);
    logic [7:0] regs [0:15];
    int wait_cnt;
    int conv_cnt;
    int n_conv;

    // Acquisition and conversion both counted in conversion clocks
    function automatic int conv_len(input logic [7:0] c2);
        int conversion_clock_period;
        int acq;
        conversion_clock_period = (c2[1:0] == 2'b11) ? TAD_CYC + 1 : TAD_CYC;
        acq = (c2[5:3] == 3'h0) ? 0 : 3 * int'(c2[5:3]) - 1;
        return (acq + 13) * conversion_clock_period +
            ((acq == 0 && c2[1:0] == 2'b11) ? INSTR_CYC : 0);
    endfunction

    assign irq = regs[5][0] & regs[6][0] & regs[6][1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < 16; k++) begin
                if (k != 3 && k != 4) begin
                    regs[k] <= 8'h00;
                end
            end
            regs[1] <= FUSE_PB_ANALOG ? 8'h00 : 8'h07;
            ack <= 1'b0;
            wait_cnt <= 0;
            conv_cnt <= 0;
            n_conv <= 0;
            rdata <= 8'h5A;
        end else begin
            ack <= 1'b0;
            if (!ack && (we || re)) begin
                if (wait_cnt < (slow ? 3 : 0)) begin
                    wait_cnt <= wait_cnt + 1;
                end else begin
                    ack <= 1'b1;
                    wait_cnt <= 0;
                    rdata <= regs[addr];
                    if (we && addr == 4'h0) begin
                        // Start ignored while switched off or busy
                        regs[0] <= wdata[0] ? wdata : wdata & 8'hFD;
                        if (wdata[1:0] == 2'b11 && conv_cnt == 0) begin
                            conv_cnt <= conv_len(regs[2]);
                            n_conv <= n_conv + 1;
                        end
                    end else if (we) begin
                        regs[addr] <= wdata;
                    end
                end
            end else if (!ack) begin
                rdata <= ~rdata;
            end
            // Only completion is visible, no phase status
            if (conv_cnt == 1) begin
                regs[0][1] <= 1'b0;
                regs[5][0] <= 1'b1;
                regs[3] <= 8'h0A;
                regs[4] <= {regs[0][5:2], 4'h5};
            end
            if (conv_cnt > 0) begin
                conv_cnt <= conv_cnt - 1;
            end
        end
    end
endmodule

// File: tb/test_adc_ctl.sv
// Self-checking bench for the converter sequencing controller
`timescale 1ns/1ps
module test_adc_ctl;
    import adc_ctl_pkg::*;
    logic clk, rst_n, avs_read, avs_write, avs_wait, slow, saw_sleep;
    logic dev_we, dev_re, dev_ack, dev_irq, clk_hold, sleep_req;
    logic [2:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] dev_addr;
    logic [7:0] dev_wdata, dev_rdata;
    logic [2:0] codes [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    logic [15:0] fosc [8] = '{16'h09C4, 16'h1388, 16'h2710, 16'h4E20,
        16'h9C40, 16'h9C40, 16'h03E8, 16'h07D0};
    int failures, n_checks;

    adc_ctl dut (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_wait), .DEV_ADDR(dev_addr),
        .DEV_WDATA(dev_wdata), .DEV_WE(dev_we), .DEV_RE(dev_re),
        .DEV_RDATA(dev_rdata), .DEV_ACK(dev_ack), .DEV_IRQ(dev_irq),
        .CLK_HOLD(clk_hold), .SLEEP_REQ(sleep_req));
    adc_dev_model dev (.clk(clk), .rst_n(rst_n), .addr(dev_addr),
        .wdata(dev_wdata), .we(dev_we), .re(dev_re), .slow(slow),
        .rdata(dev_rdata), .ack(dev_ack), .irq(dev_irq));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        if (sleep_req === 1'b1) begin
            saw_sleep <= 1'b1;
        end
    end

    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask

    // One Avalon access, held until waitrequest is sampled low
    task automatic avs(input logic wr, input logic [2:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_wait !== 1'b0 && n < 50);
        if (avs_wait !== 1'b0) begin
            failures++;
            $display("wrong value at %0t: register bus never answered",
                $time);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_done;
        int n;
        n = 0;
        do begin
            avs(1'b0, REG_CMD, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 300);
        if (rd[1] !== 1'b1) begin
            failures++;
            $display("wrong value at %0t: conversion never completed",
                $time);
        end
    endtask

    task automatic reset_values;
        avs(1'b0, REG_CMD, 32'h0);
        chk(rd, 32'h0, "status");
        avs(1'b0, REG_TAD, 32'h0);
        chk(rd, {16'h0, TAD_RESET}, "tad");
        avs(1'b0, REG_FOSC, 32'h0);
        chk(rd, {16'h0, FOSC_RESET}, "fosc");
        avs(1'b0, 3'h6, 32'h0);
        chk(rd, 32'h0, "unmapped");
        chk(dev.regs[1], 32'h0, "port code after reset");
        $display("reset values done");
    endtask

    // One conversion per row: codes, modes and channels vary by row
    task automatic convert(input int i);
        logic [31:0] cfg;
        logic [12:0] mask;
        logic [3:0] pc, ch;
        logic [2:0] cs, acq;
        pc = 4'(i);
        ch = 4'(i % 13);
        cs = codes[i % 8];
        acq = 3'((i + 2) % 8);
        cfg = {15'h0, (i % 8 == 7), cs, acq, ch, pc[1], pc[0], pc};
        slow <= pc[0];
        avs(1'b1, REG_FOSC, {16'h0, fosc[i % 8]});
        avs(1'b1, REG_CFG, cfg);
        avs(1'b1, REG_CMD, {30'h0, pc[0], 1'b1});
        wait_done();
        chk(rd, 32'h2, "status after run");
        avs(1'b0, REG_RESULT, 32'h0);
        chk(rd, {20'h0, 4'hA, ch, 4'h5}, "result");
        chk(dev.regs[1], {2'b0, pc[1], pc[0], pc}, "ctrl1");
        chk(dev.regs[2], {2'b0, acq, cs}, "ctrl2");
        mask = (pc < 3) ? 13'h1FFF : 13'h1FFF >> (pc - 4'h2);
        chk({dev.regs[8], dev.regs[7]}, {3'b0, mask}, "dir");
        chk(dev.regs[0], {2'b0, ch, 2'b01}, "ctrl0");
        chk(dev.regs[5], 8'h0, "flag");
        chk(dev.regs[6], {6'h0, pc[0], pc[0]}, "irq en");
    endtask

    task automatic refusals;
        int k;
        logic [31:0] bad [3] = '{32'h0000_0000, 32'h0001_6000,
            32'h0000_4000};
        logic [15:0] bf [3] = '{16'h9C40, 16'h07D0, 16'h01F4};
        for (k = 0; k < 3; k++) begin
            avs(1'b1, REG_FOSC, {16'h0, bf[k]});
            avs(1'b1, REG_CFG, bad[k] & 32'hFFFE_FFFF);
            avs(1'b1, REG_CMD, 32'h1);
            avs(1'b0, REG_CMD, 32'h0);
            chk(rd & 32'h5, 32'h4, "err flag");
        end
        chk(dev.n_conv, 16, "no conversion on error");
        avs(1'b1, REG_FOSC, 32'h9C40);
        avs(1'b1, REG_CFG, 32'h4540);
        avs(1'b1, REG_CMD, 32'h1);
        avs(1'b1, REG_CFG, 32'h0);
        avs(1'b1, REG_TAD, 32'h7);
        wait_done();
        avs(1'b0, REG_CFG, 32'h0);
        chk(rd, 32'h4540, "cfg held while busy");
        avs(1'b0, REG_TAD, 32'h0);
        chk(rd, 32'h2, "tad held while busy");
        $display("refusals done");
    endtask

    initial begin
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 3'h0;
        avs_writedata = 32'h0;
        slow = 1'b0;
        saw_sleep = 1'b0;
        failures = 0;
        n_checks = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        reset_values();
        avs(1'b1, REG_TAD, 32'h2);
        avs(1'b1, REG_ACQ_WAIT, 32'h4);
        for (int i = 0; i < 16; i++) begin
            convert(i);
        end
        chk(saw_sleep, 1'b1, "sleep request");
        $display("conversions done");
        refusals();
        end_sim();
    end

    initial begin
        #(8 * 60000);
        failures++;
        end_sim();
    end
endmodule
